// ==== rtl/ppp_map.svh ====
// Constants of the primary-port host: bus command codes and wait limits.
// Assumes inclusion by the package and the host module only.
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH
`define PPP_CMD_MEM_RD 4'h6
`define PPP_CMD_MEM_WR 4'h7
`define PPP_CMD_CFG_RD 4'hA
`define PPP_CMD_CFG_WR 4'hB
`define PPP_DEVSEL_WAIT 4'h5
`define PPP_TRDY_WAIT 4'hF
`define PPP_AD_WIDTH 64
`endif

// ==== rtl/ppp_pkg.sv ====
// Types of the primary-port host: command, answer, pin groups and state.
// Assumes the map header sits beside it in rtl/.
`default_nettype none
`include "ppp_map.svh"
package ppp_pkg;
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_DATA, L_TURN, L_CHECK} ppp_lstate_type;
  typedef struct packed {
    logic write;
    logic cfg;
    logic wide;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0] be;
  } ppp_cmd_type;
  typedef struct packed {
    logic [63:0] data;
    logic ack64;
    logic abort;
    logic retry;
    logic perr;
  } ppp_rsp_type;
  typedef struct packed {
    logic [63:0] ad;
    logic [7:0] cbe_n;
    logic par;
    logic par64;
    logic frame_n;
    logic irdy_n;
    logic req64_n;
    logic perr_n;
  } ppp_drive_type;
  typedef struct packed {
    logic [63:0] ad;
    logic par;
    logic par64;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic ack64_n;
    logic serr_n;
    logic inta_n;
  } ppp_sense_type;
  typedef struct packed {
    logic rst_s1, rst_s2, mode_s1, mode_s2, req_s1, req_s2;
    logic [7:2] ereq_n_s1, ereq_n_s2;
    logic done_tgl;
    ppp_lstate_type state;
    logic [3:0] cnt;
    ppp_drive_type drv, oe;
    logic grant_o, grant_oe, request_o, request_oe, idsel, bus_rst_n;
    ppp_rsp_type rsp;
  } ppp_link_type;
  typedef struct packed {
    logic req_tgl, done_s1, done_s2, done_s3, ready, rsp_valid;
    ppp_cmd_type cmd;
    ppp_rsp_type rsp;
    logic inta_s1, inta_s2, serr_s1, serr_s2, speed, slot_n;
    logic [7:2] gnt_s1, gnt_s2;
  } ppp_user_type;
  // Even parity over one half of the bus and its four lane enables
  function automatic logic ppp_parity(input logic [35:0] v);
    return ^v;
  endfunction : ppp_parity
endpackage : ppp_pkg
`default_nettype wire

// ==== rtl/ppp_host.sv ====
// Host for the primary 64-bit port: bus master, external arbiter and strap driver.
// Assumes the port clock comes from the bench; straps are levels sampled by the device.
// What this block does
// - Address and data share one 64-bit multiplexed bus.
// - Command in address phase, active-low byte enables in data phase, same eight lines.
// - Target drives 64-bit acknowledge; master samples it; released at end.
// - Master drives 64-bit request low with the frame for wide commands only, releases at end.
// - Lower parity is even over data 31..0 and lanes 3..0.
// - Upper parity is even over data 63..32 and lanes 7..4.
// - Requests 4..2 are inputs driven by external masters.
// - Shared requests 7..5 always go to the device's shared request lines; no software selection.
// - Target drives device select low; master samples it; released at end.
// - Master drives frame low for the address phase, high for the data phase, releases it at the end.
// - Master receiving read data with bad parity drives parity error low for one clock, then high for one, then releases it.
// - Port reset is active low and asynchronous.
// - A data phase completes when both initiator and target show ready.
`timescale 1ns/1ns
`default_nettype none
`include "ppp_map.svh"
module ppp_host (
  input wire logic clk,
  input wire logic srst,
  input wire logic port_bus_clock,
  input wire ppp_pkg::ppp_cmd_type cmd_data,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output ppp_pkg::ppp_rsp_type rsp_data,
  output logic rsp_valid,
  input wire logic cfg_ext_arbiter,
  input wire logic cfg_fast_clock,
  input wire logic cfg_slot64,
  input wire logic [7:2] ext_req,
  output logic [7:2] ext_gnt,
  output logic irq,
  output logic sys_error,
  input wire ppp_pkg::ppp_sense_type pin_i,
  output ppp_pkg::ppp_drive_type pin_o,
  output ppp_pkg::ppp_drive_type pin_oe,
  output logic idsel,
  output logic port_bus_reset_n,
  output logic port_speed_strap,
  output logic slot_width_wide_n,
  input wire logic port_grant_one_n_i,
  output logic port_grant_one_n_o,
  output logic port_grant_one_n_oe,
  input wire logic port_request_one_n_i,
  output logic port_request_one_n_o,
  output logic port_request_one_n_oe,
  output logic [4:2] port_request_in_n,
  output logic [7:5] shared_request_n,
  input wire logic [4:2] port_grant_out_n,
  input wire logic [7:5] shared_grant_n
);
  import ppp_pkg::*;

  ppp_link_type link_ff, nxt_link;
  ppp_user_type user_ff, nxt_user;
  logic lrst;
  logic pend;
  logic may_go;
  logic mism;

  assign lrst = link_ff.rst_s2;

  // Link side: transaction sequencer, arbitration and parity on the port clock
  always_comb begin
    nxt_link = link_ff;
    nxt_link.rst_s1 = srst;
    nxt_link.rst_s2 = link_ff.rst_s1;
    nxt_link.mode_s1 = cfg_ext_arbiter;
    nxt_link.mode_s2 = link_ff.mode_s1;
    nxt_link.req_s1 = user_ff.req_tgl;
    nxt_link.req_s2 = link_ff.req_s1;
    nxt_link.ereq_n_s1 = ~ext_req;
    nxt_link.ereq_n_s2 = link_ff.ereq_n_s1;
    nxt_link.bus_rst_n = !link_ff.rst_s2;
    pend = link_ff.req_s2 != link_ff.done_tgl;
    mism = 1'b0;
    // Parity follows the driven address or data by one clock
    nxt_link.drv.par = ppp_parity({link_ff.drv.ad[31:0], link_ff.drv.cbe_n[3:0]});
    nxt_link.drv.par64 = ppp_parity({link_ff.drv.ad[63:32], link_ff.drv.cbe_n[7:4]});
    nxt_link.oe.par = link_ff.oe.ad[0];
    nxt_link.oe.par64 = link_ff.oe.ad[32];
    // Arbiter mode decides which of the pair is driven
    nxt_link.grant_oe = link_ff.mode_s2;
    nxt_link.request_oe = !link_ff.mode_s2;
    nxt_link.request_o = !(pend && link_ff.state == L_IDLE);
    nxt_link.grant_o = !(link_ff.mode_s2 && !pend && link_ff.state == L_IDLE && !port_request_one_n_i);
    may_go = link_ff.mode_s2 ? link_ff.grant_o : !port_grant_one_n_i;
    case (link_ff.state)
      L_IDLE: begin
        nxt_link.oe.ad = '0;
        nxt_link.oe.cbe_n = '0;
        nxt_link.oe.frame_n = 1'b0;
        nxt_link.oe.irdy_n = 1'b0;
        nxt_link.oe.req64_n = 1'b0;
        nxt_link.oe.perr_n = 1'b0;
        if (pend && may_go && pin_i.frame_n && pin_i.irdy_n) begin
          nxt_link.state = L_ADDR;
          nxt_link.cnt = 4'h0;
          nxt_link.rsp = '0;
          nxt_link.drv.ad = {32'h0, user_ff.cmd.addr};
          nxt_link.oe.ad = {{32{user_ff.cmd.wide}}, 32'hFFFFFFFF};
          nxt_link.drv.cbe_n[3:0] = user_ff.cmd.cfg
            ? (user_ff.cmd.write ? `PPP_CMD_CFG_WR : `PPP_CMD_CFG_RD)
            : (user_ff.cmd.write ? `PPP_CMD_MEM_WR : `PPP_CMD_MEM_RD);
          nxt_link.drv.cbe_n[7:4] = 4'h0;
          nxt_link.oe.cbe_n = {{4{user_ff.cmd.wide}}, 4'hF};
          nxt_link.drv.frame_n = 1'b0;
          nxt_link.oe.frame_n = 1'b1;
          nxt_link.drv.irdy_n = 1'b1;
          nxt_link.oe.irdy_n = 1'b1;
          nxt_link.drv.req64_n = !user_ff.cmd.wide;
          nxt_link.oe.req64_n = 1'b1;
          nxt_link.idsel = user_ff.cmd.cfg;
        end
      end
      L_ADDR: begin
        nxt_link.state = L_DATA;
        nxt_link.idsel = 1'b0;
        nxt_link.drv.frame_n = 1'b1;
        nxt_link.drv.irdy_n = 1'b0;
        nxt_link.drv.req64_n = 1'b1;
        nxt_link.drv.ad = user_ff.cmd.data;
        nxt_link.oe.ad = user_ff.cmd.write ? {{32{user_ff.cmd.wide}}, 32'hFFFFFFFF} : '0;
        nxt_link.drv.cbe_n = ~user_ff.cmd.be;
      end
      L_DATA: begin
        if (link_ff.cnt != `PPP_TRDY_WAIT) begin
          nxt_link.cnt = link_ff.cnt + 4'h1;
        end
        if (!pin_i.devsel_n && !pin_i.trdy_n) begin
          nxt_link.state = L_TURN;
          nxt_link.rsp.ack64 = !pin_i.ack64_n;
          nxt_link.rsp.data = {pin_i.ack64_n ? 32'h0 : pin_i.ad[63:32], pin_i.ad[31:0]};
        end else if (!pin_i.devsel_n && !pin_i.stop_n) begin
          nxt_link.state = L_TURN;
          nxt_link.rsp.retry = 1'b1;
        end else if ((pin_i.devsel_n && link_ff.cnt == `PPP_DEVSEL_WAIT) || link_ff.cnt == `PPP_TRDY_WAIT) begin
          nxt_link.state = L_TURN;
          nxt_link.rsp.abort = 1'b1;
        end
        if (nxt_link.state == L_TURN) begin
          nxt_link.drv.irdy_n = 1'b1;
          nxt_link.oe.frame_n = 1'b0;
          nxt_link.oe.req64_n = 1'b0;
          nxt_link.oe.ad = '0;
          nxt_link.oe.cbe_n = '0;
        end
      end
      L_TURN: begin
        nxt_link.state = L_CHECK;
        nxt_link.oe.irdy_n = 1'b0;
        if (!user_ff.cmd.write && !link_ff.rsp.abort && !link_ff.rsp.retry) begin
          mism = (pin_i.par != ppp_parity({link_ff.rsp.data[31:0], link_ff.drv.cbe_n[3:0]}))
            || (link_ff.rsp.ack64 && pin_i.par64 != ppp_parity({link_ff.rsp.data[63:32], link_ff.drv.cbe_n[7:4]}));
        end
        if (mism) begin
          nxt_link.rsp.perr = 1'b1;
          nxt_link.drv.perr_n = 1'b0;
          nxt_link.oe.perr_n = 1'b1;
        end
      end
      L_CHECK: begin
        nxt_link.state = L_IDLE;
        nxt_link.drv.perr_n = 1'b1;
        nxt_link.done_tgl = !link_ff.done_tgl;
      end
      default: begin
        nxt_link.state = L_IDLE;
      end
    endcase
    if (link_ff.rst_s2) begin
      nxt_link.state = L_IDLE;
      nxt_link.oe = '0;
      nxt_link.done_tgl = 1'b0;
      nxt_link.grant_o = 1'b1;
      nxt_link.request_o = 1'b1;
      nxt_link.idsel = 1'b0;
      nxt_link.cnt = 4'h0;
      nxt_link.rsp = '0;
    end
  end

  // Link side register
  always_ff @(posedge port_bus_clock) begin
    link_ff <= nxt_link;
  end

  // User side: command hand-off, answer capture, strap and status syncing
  always_comb begin
    nxt_user = user_ff;
    nxt_user.rsp_valid = 1'b0;
    nxt_user.done_s1 = link_ff.done_tgl;
    nxt_user.done_s2 = user_ff.done_s1;
    nxt_user.done_s3 = user_ff.done_s2;
    nxt_user.inta_s1 = !pin_i.inta_n;
    nxt_user.inta_s2 = user_ff.inta_s1;
    nxt_user.serr_s1 = !pin_i.serr_n;
    nxt_user.serr_s2 = user_ff.serr_s1;
    nxt_user.gnt_s1 = ~{shared_grant_n, port_grant_out_n};
    nxt_user.gnt_s2 = user_ff.gnt_s1;
    nxt_user.speed = cfg_fast_clock;
    nxt_user.slot_n = !cfg_slot64;
    if (cmd_valid && user_ff.ready) begin
      nxt_user.cmd = cmd_data;
      nxt_user.req_tgl = !user_ff.req_tgl;
      nxt_user.ready = 1'b0;
    end
    if (user_ff.done_s2 != user_ff.done_s3) begin
      nxt_user.rsp = link_ff.rsp;
      nxt_user.rsp_valid = 1'b1;
      nxt_user.ready = 1'b1;
    end
    if (srst) begin
      nxt_user = '0;
      nxt_user.ready = 1'b1;
      nxt_user.slot_n = 1'b1;
    end
  end

  // User side register
  always_ff @(posedge clk) begin
    user_ff <= nxt_user;
  end

  // Outputs, each straight from a register
  assign cmd_ready = user_ff.ready;
  assign rsp_data = user_ff.rsp;
  assign rsp_valid = user_ff.rsp_valid;
  assign ext_gnt = user_ff.gnt_s2;
  assign irq = user_ff.inta_s2;
  assign sys_error = user_ff.serr_s2;
  assign port_speed_strap = user_ff.speed;
  assign slot_width_wide_n = user_ff.slot_n;
  assign pin_o = link_ff.drv;
  assign pin_oe = link_ff.oe;
  assign idsel = link_ff.idsel;
  assign port_bus_reset_n = link_ff.bus_rst_n;
  assign port_grant_one_n_o = link_ff.grant_o;
  assign port_grant_one_n_oe = link_ff.grant_oe;
  assign port_request_one_n_o = link_ff.request_o;
  assign port_request_one_n_oe = link_ff.request_oe;
  assign port_request_in_n = link_ff.ereq_n_s2[4:2];
  assign shared_request_n = link_ff.ereq_n_s2[7:5];

  // Checks on the port clock
  default clocking @(posedge port_bus_clock); endclocking
  default disable iff (lrst);

  sequence s_addr;
    link_ff.state == L_ADDR && !link_ff.drv.frame_n && link_ff.oe.frame_n;
  endsequence
  sequence s_data;
    link_ff.state == L_DATA && link_ff.drv.frame_n && !link_ff.drv.irdy_n && link_ff.oe.irdy_n;
  endsequence

  frame_then_ready_a: assert property (s_addr |=> s_data)
    else $error("frame phase not followed by data phase");
  low_parity_a: assert property (link_ff.oe.ad[0] |=> link_ff.oe.par
    && link_ff.drv.par == ^{$past(link_ff.drv.ad[31:0]), $past(link_ff.drv.cbe_n[3:0])})
    else $error("lower parity wrong or late");
  high_parity_a: assert property (link_ff.oe.ad[32] |=> link_ff.oe.par64
    && link_ff.drv.par64 == ^{$past(link_ff.drv.ad[63:32]), $past(link_ff.drv.cbe_n[7:4])})
    else $error("upper parity wrong or late");
  wide_request_a: assert property (link_ff.state == L_ADDR |->
    link_ff.drv.req64_n == !user_ff.cmd.wide && link_ff.oe.ad[32] == user_ff.cmd.wide)
    else $error("wide request does not match command");
  phase_done_a: assert property (link_ff.state == L_DATA && !pin_i.trdy_n && !pin_i.devsel_n
    |=> link_ff.state == L_TURN ##1 link_ff.state == L_CHECK ##1 link_ff.state == L_IDLE)
    else $error("completed data phase not closed");
  abort_bound_a: assert property ($rose(link_ff.state == L_DATA) |-> ##[1:16] link_ff.state != L_DATA)
    else $error("data phase exceeds wait limit");
  lane_enable_a: assert property (link_ff.state == L_DATA |-> link_ff.drv.cbe_n == ~user_ff.cmd.be)
    else $error("byte enables not taken from command");
  parity_error_a: assert property (link_ff.state == L_TURN && mism
    |=> !link_ff.drv.perr_n && link_ff.oe.perr_n ##1 link_ff.drv.perr_n)
    else $error("parity error not signalled");
  // Direction follows the synced mode once it has settled and the port is out of reset
  arb_mode_a: assert property ($stable(link_ff.mode_s2) && link_ff.bus_rst_n |->
    link_ff.grant_oe == link_ff.mode_s2 && link_ff.request_oe != link_ff.mode_s2)
    else $error("grant and request direction wrong");
  config_select_a: assert property (link_ff.state == L_ADDR |-> link_ff.idsel == user_ff.cmd.cfg)
    else $error("select line wrong in address phase");
  narrow_answer_a: assert property (link_ff.state == L_TURN && !link_ff.rsp.ack64
    |-> link_ff.rsp.data[63:32] == 32'h0)
    else $error("upper half kept without wide acknowledge");
endmodule : ppp_host
`default_nettype wire

// ==== tb/ppp_dev_model.sv ====
// Far-side device of the primary port: a one-word target plus the device arbiter.
// Assumes the host pins move on port_bus_clock; control lines have pull-ups.
`timescale 1ns/1ns
`default_nettype none
module ppp_dev_model (
  input wire logic port_bus_clock,
  input wire logic port_bus_reset_n,
  input wire ppp_pkg::ppp_drive_type pin_o,
  input wire ppp_pkg::ppp_drive_type pin_oe,
  input wire logic idsel,
  input wire logic port_grant_one_n_o,
  input wire logic port_grant_one_n_oe,
  input wire logic port_request_one_n_o,
  input wire logic port_request_one_n_oe,
  input wire logic [4:2] port_request_in_n,
  input wire logic [7:5] shared_request_n,
  input wire logic cfg_ext_arbiter,
  input wire logic [2:0] mode,
  input wire logic int_req,
  input wire logic serr_req,
  output ppp_pkg::ppp_sense_type pin_i,
  output logic port_grant_one_n_i,
  output logic port_request_one_n_i,
  output logic [4:2] port_grant_out_n,
  output logic [7:5] shared_grant_n,
  output logic [3:0] cap_cmd,
  output logic cap_r64,
  output logic apar_ok,
  output logic dpar_ok
);
  import ppp_pkg::*;
  logic [63:0] mem, dad, last, a;
  logic [7:0] cb, c;
  logic [1:0] st;
  logic doe, poe, dgnt, trdy, dev, stp, ack, par, par64;
  // Wire levels; undriven data shows the inverse of its last value
  always_comb begin
    pin_i.ad = (pin_oe.ad & pin_o.ad) | ({64{doe}} & dad) | (~pin_oe.ad & ~{64{doe}} & ~last);
    pin_i.par = pin_oe.par ? pin_o.par : poe ? par : ~last[0];
    pin_i.par64 = pin_oe.par64 ? pin_o.par64 : poe ? par64 : ~last[32];
    pin_i.frame_n = !(pin_oe.frame_n && !pin_o.frame_n);
    pin_i.irdy_n = !(pin_oe.irdy_n && !pin_o.irdy_n);
    pin_i.trdy_n = trdy;
    pin_i.devsel_n = dev;
    pin_i.stop_n = stp;
    pin_i.ack64_n = ack;
    pin_i.serr_n = !serr_req;
    pin_i.inta_n = !int_req;
    port_grant_one_n_i = port_grant_one_n_oe ? port_grant_one_n_o : cfg_ext_arbiter | dgnt;
    port_request_one_n_i = port_request_one_n_oe ? port_request_one_n_o : !cfg_ext_arbiter;
  end
  // Target walk: decode, answer, data, parity
  always_ff @(posedge port_bus_clock or negedge port_bus_reset_n) begin
    if (!port_bus_reset_n) begin
      st <= 2'h0;
      {doe, poe, apar_ok, dpar_ok, cap_r64} <= 5'h0;
      {trdy, dev, stp, ack, dgnt} <= 5'h1F;
      {port_grant_out_n, shared_grant_n} <= 6'h3F;
      mem <= 64'h0;
      last <= 64'h0;
      cap_cmd <= 4'h0;
    end else begin
      last <= pin_i.ad;
      dgnt <= port_request_one_n_i;
      port_grant_out_n <= port_request_in_n;
      shared_grant_n <= shared_request_n;
      case (st)
        2'h0: if (!pin_i.frame_n) begin
          a <= pin_i.ad;
          c <= pin_o.cbe_n;
          cap_cmd <= pin_o.cbe_n[3:0];
          cap_r64 <= !pin_o.req64_n;
          if (mode != 3'h2 && (idsel || pin_o.cbe_n[3:1] != 3'h5)) st <= 2'h1;
        end
        2'h1: begin
          // Address parity stands one clock after the address
          apar_ok <= (pin_i.par == ^{a[31:0], c[3:0]}) && (pin_i.par64 == ^{a[63:32], c[7:4]});
          dev <= 1'b0;
          trdy <= (mode == 3'h3);
          stp <= (mode != 3'h3);
          ack <= !(cap_r64 && mode != 3'h1);
          doe <= !cap_cmd[0];
          dad <= mem;
          st <= 2'h2;
        end
        2'h2: begin
          cb <= pin_o.cbe_n;
          for (int i = 0; i < 8; i++) begin
            if (!pin_i.irdy_n && !trdy && cap_cmd[0] && !pin_o.cbe_n[i] && (i < 4 || !ack)) begin
              mem[8*i+:8] <= pin_i.ad[8*i+:8];
            end
          end
          par <= ^{dad[31:0], pin_o.cbe_n[3:0]} ^ (mode == 3'h4);
          par64 <= ^{dad[63:32], pin_o.cbe_n[7:4]};
          poe <= !cap_cmd[0];
          doe <= 1'b0;
          {trdy, dev, stp, ack} <= 4'hF;
          st <= 2'h3;
        end
        default: begin
          if (cap_cmd[0]) begin
            dpar_ok <= (pin_i.par == ^{last[31:0], cb[3:0]})
              && (!cap_r64 || pin_i.par64 == ^{last[63:32], cb[7:4]});
          end
          poe <= 1'b0;
          st <= 2'h0;
        end
      endcase
    end
  end
endmodule : ppp_dev_model
`default_nettype wire

// ==== tb/tb_pci_primary_port_signals.sv ====
// Bench of the primary-port host against the device model.
// Assumes the host and the model share the pin names of the host's ports.
`timescale 1ns/1ns
`default_nettype none
module tb_pci_primary_port_signals;
  import ppp_pkg::*;
  logic clk, srst, port_bus_clock, cmd_valid, cmd_ready, rsp_valid, cfg_ext_arbiter, cfg_fast_clock, cfg_slot64;
  logic irq, sys_error, idsel, port_bus_reset_n, port_speed_strap, slot_width_wide_n, int_req, serr_req;
  logic port_grant_one_n_i, port_grant_one_n_o, port_grant_one_n_oe, cap_r64, apar_ok, dpar_ok;
  logic port_request_one_n_i, port_request_one_n_o, port_request_one_n_oe;
  logic [7:2] ext_req, ext_gnt;
  logic [4:2] port_request_in_n, port_grant_out_n;
  logic [7:5] shared_request_n, shared_grant_n;
  logic [3:0] cap_cmd;
  logic [2:0] mode;
  ppp_cmd_type cmd_data;
  ppp_rsp_type rsp_data, r;
  ppp_sense_type pin_i;
  ppp_drive_type pin_o, pin_oe;
  int fail_count, n_checks, cyc;
  localparam logic [63:0] D1 = 64'h8421C3A50F1E7B69;
  localparam logic [63:0] D2 = 64'h13579BDF2468ACE0;
  localparam logic [63:0] D3 = 64'hA5000000000000C3;
  ppp_host uut (.clk, .srst, .port_bus_clock, .cmd_data, .cmd_valid, .cmd_ready, .rsp_data, .rsp_valid,
    .cfg_ext_arbiter, .cfg_fast_clock, .cfg_slot64, .ext_req, .ext_gnt, .irq, .sys_error, .pin_i, .pin_o,
    .pin_oe, .idsel, .port_bus_reset_n, .port_speed_strap, .slot_width_wide_n, .port_grant_one_n_i,
    .port_grant_one_n_o, .port_grant_one_n_oe, .port_request_one_n_i, .port_request_one_n_o,
    .port_request_one_n_oe, .port_request_in_n, .shared_request_n, .port_grant_out_n, .shared_grant_n);
  ppp_dev_model dev (.port_bus_clock, .port_bus_reset_n, .pin_o, .pin_oe, .idsel, .port_grant_one_n_o,
    .port_grant_one_n_oe, .port_request_one_n_o, .port_request_one_n_oe, .port_request_in_n,
    .shared_request_n, .cfg_ext_arbiter, .mode, .int_req, .serr_req, .pin_i, .port_grant_one_n_i,
    .port_request_one_n_i, .port_grant_out_n, .shared_grant_n, .cap_cmd, .cap_r64, .apar_ok, .dpar_ok);
  // User clock and an unrelated port clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    port_bus_clock = 1'b0;
    #17;
    forever begin
      #62 port_bus_clock = 1'b1;
      #63 port_bus_clock = 1'b0;
    end
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  task stop_test;
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic c, input logic wd, input logic [63:0] d, input logic [7:0] b);
    int i;
    while (cmd_ready !== 1'b1) step;
    cmd_data = '{w, c, wd, 32'h00001040, d, b};
    cmd_valid = 1'b1;
    step;
    cmd_valid = 1'b0;
    for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) step;
    chk(rsp_valid, 1'b1);
    r = rsp_data;
  endtask : xfer
  task t_pins;
    {cfg_fast_clock, cfg_slot64} = 2'h3;
    repeat (8) step;
    chk({port_speed_strap, slot_width_wide_n, port_bus_reset_n}, 3'h5);
    {cfg_fast_clock, cfg_slot64} = 2'h0;
    repeat (4) step;
    chk({port_speed_strap, slot_width_wide_n}, 2'h1);
  endtask : t_pins
  task t_wide;
    xfer(1'b1, 1'b0, 1'b1, D1, 8'hFF);
    chk({cap_cmd, cap_r64, apar_ok, dpar_ok, r.ack64}, 8'h7F);
    xfer(1'b0, 1'b0, 1'b1, 64'h0, 8'hFF);
    chk({cap_cmd, apar_ok, r.perr}, 6'h1A);
    chk(r.data, D1);
  endtask : t_wide
  task t_narrow;
    mode = 3'h1;
    xfer(1'b1, 1'b0, 1'b1, D2, 8'hFF);
    chk(r.ack64, 1'b0);
    xfer(1'b0, 1'b0, 1'b1, 64'h0, 8'hFF);
    chk(r.data, {32'h0, D2[31:0]});
    mode = 3'h0;
    xfer(1'b1, 1'b0, 1'b1, D3, 8'h81);
    xfer(1'b0, 1'b0, 1'b0, 64'h0, 8'hFF);
    chk(cap_r64, 1'b0);
    xfer(1'b0, 1'b0, 1'b1, 64'h0, 8'hFF);
    chk(r.data, {D3[63:56], D1[55:32], D2[31:8], D3[7:0]});
  endtask : t_narrow
  task t_cfg;
    xfer(1'b1, 1'b1, 1'b0, D1, 8'h0F);
    chk({cap_cmd, r.abort}, 5'h16);
    xfer(1'b0, 1'b1, 1'b0, 64'h0, 8'h0F);
    chk({cap_cmd, r.abort}, 5'h14);
  endtask : t_cfg
  task t_errs;
    for (int m = 2; m < 5; m++) begin
      mode = 3'(m);
      xfer(1'b0, 1'b0, 1'b1, 64'h0, 8'hFF);
      chk({r.abort, r.retry, r.perr}, 3'h1 << (4 - m));
    end
    mode = 3'h0;
  endtask : t_errs
  task t_arb;
    ext_req = 6'h2D;
    repeat (20) step;
    chk({shared_request_n, port_request_in_n, ext_gnt}, 12'h4AD);
    ext_req = 6'h00;
    cfg_ext_arbiter = 1'b1;
    repeat (20) step;
    chk({port_grant_one_n_oe, port_request_one_n_oe}, 2'h2);
    xfer(1'b1, 1'b0, 1'b0, D2, 8'h0F);
    chk(r.abort, 1'b0);
    cfg_ext_arbiter = 1'b0;
    repeat (20) step;
    chk({port_grant_one_n_oe, port_request_one_n_oe}, 2'h1);
  endtask : t_arb
  task t_irq;
    int_req = 1'b1;
    repeat (5) step;
    chk({irq, sys_error}, 2'h2);
    serr_req = 1'b1;
    repeat (5) step;
    chk(sys_error, 1'b1);
    {int_req, serr_req} = 2'h0;
    repeat (5) step;
    chk({irq, sys_error}, 2'h0);
  endtask : t_irq
  // Main sequence
  initial begin
    {srst, cmd_valid, cfg_ext_arbiter, cfg_fast_clock, cfg_slot64, int_req, serr_req} = 7'h40;
    {cmd_data, ext_req, mode} = '0;
    {fail_count, n_checks, cyc} = '0;
    repeat (10) step;
    chk(port_bus_reset_n, 1'b0);
    repeat (2) step;
    srst = 1'b0;
    t_pins;
    t_wide;
    t_narrow;
    t_cfg;
    t_errs;
    t_arb;
    t_irq;
    stop_test;
  end
endmodule : tb_pci_primary_port_signals
`default_nettype wire
